// *** rtl/pwm_timer_pkg.sv ***
// register map, field positions and reset values of the match-based pwm timer
// assumes a 32-bit software port with word-aligned byte addresses
package pwm_timer_pkg;
   // ------------------------------------------------------------
   // sizes
   // ------------------------------------------------------------
   localparam int MATCH_COUNT = 7;
   localparam int CHAN_COUNT  = 6;
   localparam int ADDR_WIDTH  = 8;
   localparam int DATA_WIDTH  = 32;

   // ------------------------------------------------------------
   // offsets
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_OFFSET      = 8'h00;
   localparam logic [7:0] COUNT_OFFSET     = 8'h04;
   localparam logic [7:0] PRESCALE_OFFSET  = 8'h08;
   localparam logic [7:0] PRECOUNT_OFFSET  = 8'h0C;
   localparam logic [7:0] MATCH_CFG_OFFSET = 8'h10;
   localparam logic [7:0] MATCH0_OFFSET    = 8'h14;
   localparam logic [7:0] PWM_CFG_OFFSET   = 8'h30;
   localparam logic [7:0] RELEASE_OFFSET   = 8'h34;
   localparam logic [7:0] STATUS_OFFSET    = 8'h38;
   localparam logic [7:0] MASK_OFFSET      = 8'h3C;

   // ------------------------------------------------------------
   // control fields
   // ------------------------------------------------------------
   localparam int CTRL_WIDTH       = 7;
   localparam int CTRL_RUN_BIT     = 0;
   localparam int CTRL_HOLD_BIT    = 1;
   localparam int CTRL_PWM_BIT     = 2;
   localparam int CTRL_COUNT_BIT   = 3;
   localparam int CTRL_RISE_BIT    = 4;
   localparam int CTRL_FALL_BIT    = 5;
   localparam int CTRL_CAPSEL_BIT  = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;

   // match_cfg: three bits per match register
   localparam int MCFG_INT_BIT   = 0;
   localparam int MCFG_RST_BIT   = 1;
   localparam int MCFG_STOP_BIT  = 2;
   localparam int MCFG_STRIDE    = 3;
   localparam logic [20:0] MCFG_RESET = 21'h000000;

   // pwm_cfg: bit n selects double edge, bit OE_LSB+n enables channel n
   localparam int PCFG_SEL_LSB = 0;
   localparam int PCFG_OE_LSB  = 8;
   localparam logic [14:0] PCFG_RESET = 15'h0000;

   localparam logic [31:0] MATCH_RESET = 32'h00000000;
endpackage : pwm_timer_pkg

// *** rtl/pwm_channel.sv ***
// one modulated output: set and clear events folded into a held level
// assumes events are single-cycle pulses on ref_clk
`timescale 1ns/1ps
module pwm_channel (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   input  wire logic enable,
   input  wire logic set_ev,
   input  wire logic clr_ev,
   output logic      pwm_level
);
   // clear beats set, so a width equal to the cycle start stays low
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwm_level <= 1'b0;
      end else if (!enable) begin
         pwm_level <= 1'b0;
      end else if (clr_ev) begin
         pwm_level <= 1'b0;
      end else if (set_ev) begin
         pwm_level <= 1'b1;
      end
   end
endmodule : pwm_channel

// *** rtl/pwm_timer.sv ***
// match based pwm timer: prescaler, counter, seven match registers, six outputs
// assumes a single 200 MHz clock, synchronous capture inputs, one-cycle strobes
//
// Behaviour
// - seven match registers serve six single-edge, three double-edge or mixed outputs.
// - while modulating, a match on the cycle match register resets the counter and sets the period.
// - a single-edge output rises at the cycle match and falls at its own match.
// - a single-edge output whose fall coincides with the cycle start stays low.
// - a double-edge output rises at the lower-numbered match and falls at its own.
// - every output repeats at the one period of the cycle match register.
// - while modulating, new match values take effect only after release and at the cycle start; with modulation off, at once.
// - each match can interrupt, stop or reset the counter as configured.
// - the counter counts clocks or edges on a selected capture input.
// - counter and prescaler are each thirty-two bits wide.
// - with modulation disabled the block is a plain timer with quiet outputs.
// - any count value is accepted for period and width.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
module pwm_timer #(
   parameter int CNT_WIDTH = 32,
   parameter int PRE_WIDTH = 32
) (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   input  wire logic [1:0]  cap_in,
   output logic      [31:0] rdata,
   output logic             irq,
   output logic      [6:1]  pwm_out
);
   localparam int NM = pwm_timer_pkg::MATCH_COUNT;
   localparam int NC = pwm_timer_pkg::CHAN_COUNT;

   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   if (CNT_WIDTH < 2 || CNT_WIDTH > 32) begin : g_bad_cnt
      $error("CNT_WIDTH must be 2..32");
   end
   if (PRE_WIDTH < 1 || PRE_WIDTH > 32) begin : g_bad_pre
      $error("PRE_WIDTH must be 1..32");
   end

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic is_match(input logic [7:0] a);
      is_match = (a >= pwm_timer_pkg::MATCH0_OFFSET) &&
                 (a < pwm_timer_pkg::PWM_CFG_OFFSET) && (a[1:0] == 2'h0);
   endfunction : is_match

   function automatic logic [2:0] match_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - pwm_timer_pkg::MATCH0_OFFSET;
      match_idx = d[4:2];
   endfunction : match_idx

   wire       wr_ctrl  = wr_stb && addr == pwm_timer_pkg::CTRL_OFFSET;
   wire       wr_pre   = wr_stb && addr == pwm_timer_pkg::PRESCALE_OFFSET;
   wire       wr_mcfg  = wr_stb && addr == pwm_timer_pkg::MATCH_CFG_OFFSET;
   wire       wr_pcfg  = wr_stb && addr == pwm_timer_pkg::PWM_CFG_OFFSET;
   wire       wr_rel   = wr_stb && addr == pwm_timer_pkg::RELEASE_OFFSET;
   wire       wr_mask  = wr_stb && addr == pwm_timer_pkg::MASK_OFFSET;
   wire       rd_stat  = rd_stb && addr == pwm_timer_pkg::STATUS_OFFSET;
   wire       wr_match = wr_stb && is_match(addr);
   wire [2:0] wr_idx   = match_idx(addr);
   wire [2:0] rd_idx   = match_idx(addr);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [6:0]           ctrl_reg;
   logic [6:0]           ctrl_next;
   logic [PRE_WIDTH-1:0] pre_limit_reg;
   logic [PRE_WIDTH-1:0] pre_count_reg;
   logic [PRE_WIDTH-1:0] pre_count_next;
   logic [CNT_WIDTH-1:0] count_reg;
   logic [CNT_WIDTH-1:0] count_next;
   logic [20:0]          mcfg_reg;
   logic [14:0]          pcfg_reg;
   logic [NM-1:0]        release_reg;
   logic [NM-1:0]        release_next;
   logic [NM-1:0]        status_reg;
   logic [NM-1:0]        status_next;
   logic [NM-1:0]        mask_reg;
   logic [1:0]           cap_prev_reg;
   logic [CNT_WIDTH-1:0] shadow_mem [NM];
   logic [CNT_WIDTH-1:0] active_mem [NM];

   wire run_en   = ctrl_reg[pwm_timer_pkg::CTRL_RUN_BIT];
   wire hold     = ctrl_reg[pwm_timer_pkg::CTRL_HOLD_BIT];
   wire pwm_en   = ctrl_reg[pwm_timer_pkg::CTRL_PWM_BIT];
   wire cnt_mode = ctrl_reg[pwm_timer_pkg::CTRL_COUNT_BIT];

   // ------------------------------------------------------------
   // count source and prescaler
   // ------------------------------------------------------------
   wire cap_sel  = ctrl_reg[pwm_timer_pkg::CTRL_CAPSEL_BIT];
   wire cap_now  = cap_in[cap_sel];
   wire cap_old  = cap_prev_reg[cap_sel];
   wire cap_rise = cap_now && !cap_old && ctrl_reg[pwm_timer_pkg::CTRL_RISE_BIT];
   wire cap_fall = !cap_now && cap_old && ctrl_reg[pwm_timer_pkg::CTRL_FALL_BIT];
   // counter mode steps on chosen capture edges, timer mode on every clock
   wire src_ev   = cnt_mode ? (cap_rise || cap_fall) : 1'b1;
   wire active   = run_en && !hold;
   wire pre_wrap = active && src_ev && (pre_count_reg == pre_limit_reg);
   wire tick     = pre_wrap;

   // hold clears the prescaler too, so a smaller limit written under hold is never overrun
   assign pre_count_next = hold ? '0 : !active || !src_ev ? pre_count_reg :
                           pre_wrap ? '0 : pre_count_reg + PRE_WIDTH'(1);

   // ------------------------------------------------------------
   // match evaluation
   // ------------------------------------------------------------
   logic [NM-1:0] hit;
   logic [NM-1:0] rst_cfg;
   logic [NM-1:0] stop_cfg;
   logic [NM-1:0] int_cfg;

   for (genvar i = 0; i < NM; i++) begin : g_match
      // plain equality, so any period and width value is legal
      assign hit[i]      = tick && (count_reg == active_mem[i]);
      assign int_cfg[i]  = mcfg_reg[i*pwm_timer_pkg::MCFG_STRIDE +
                                    pwm_timer_pkg::MCFG_INT_BIT];
      assign rst_cfg[i]  = mcfg_reg[i*pwm_timer_pkg::MCFG_STRIDE +
                                    pwm_timer_pkg::MCFG_RST_BIT];
      assign stop_cfg[i] = mcfg_reg[i*pwm_timer_pkg::MCFG_STRIDE +
                                    pwm_timer_pkg::MCFG_STOP_BIT];
   end

   // the cycle match always restarts the count while modulating
   wire cycle_hit = hit[0];
   wire any_rst   = |(hit & rst_cfg) || (pwm_en && cycle_hit);
   wire any_stop  = |(hit & stop_cfg);
   wire apply     = pwm_en && cycle_hit;

   assign count_next = hold ? '0 : !tick ? count_reg :
                       any_rst ? '0 : count_reg + CNT_WIDTH'(1);

   // ------------------------------------------------------------
   // control, release and interrupt state
   // ------------------------------------------------------------
   assign ctrl_next = wr_ctrl ? wdata[pwm_timer_pkg::CTRL_WIDTH-1:0] :
                      any_stop ? (ctrl_reg & ~7'h01) : ctrl_reg;

   // a release written in the apply cycle survives to the next cycle
   assign release_next = (release_reg & ~(apply ? release_reg : '0)) |
                         (wr_rel ? wdata[NM-1:0] : '0);

   // new events win over the read that clears
   assign status_next = (rd_stat ? '0 : status_reg) | (hit & int_cfg);

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_reg      <= pwm_timer_pkg::CTRL_RESET;
         pre_limit_reg <= '0;
         pre_count_reg <= '0;
         count_reg     <= '0;
         mcfg_reg      <= pwm_timer_pkg::MCFG_RESET;
         pcfg_reg      <= pwm_timer_pkg::PCFG_RESET;
         release_reg   <= '0;
         status_reg    <= '0;
         mask_reg      <= '0;
         cap_prev_reg  <= 2'h0;
         irq           <= 1'b0;
      end else begin
         ctrl_reg      <= ctrl_next;
         pre_count_reg <= pre_count_next;
         count_reg     <= count_next;
         release_reg   <= release_next;
         status_reg    <= status_next;
         cap_prev_reg  <= cap_in;
         irq           <= |(status_next & mask_reg);
         if (wr_pre) begin
            pre_limit_reg <= wdata[PRE_WIDTH-1:0];
         end
         if (wr_mcfg) begin
            mcfg_reg <= wdata[20:0];
         end
         if (wr_pcfg) begin
            pcfg_reg <= wdata[14:0];
         end
         if (wr_mask) begin
            mask_reg <= wdata[NM-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // match storage
   // ------------------------------------------------------------
   // shadows take writes at once; with modulation off the compare copy
   // follows every cycle, while modulating it only moves at a cycle start
   // when released, which keeps a width change from
   // chopping the pulse that is already running
   for (genvar i = 0; i < NM; i++) begin : g_store
      wire wr_this = wr_match && (wr_idx == 3'(i));
      wire load    = !pwm_en || (apply && release_reg[i]);
      always_ff @(posedge ref_clk or posedge sys_rst) begin
         if (sys_rst) begin
            shadow_mem[i] <= CNT_WIDTH'(pwm_timer_pkg::MATCH_RESET);
            active_mem[i] <= CNT_WIDTH'(pwm_timer_pkg::MATCH_RESET);
         end else begin
            if (wr_this) begin
               shadow_mem[i] <= wdata[CNT_WIDTH-1:0];
            end
            if (load) begin
               active_mem[i] <= shadow_mem[i];
            end
         end
      end
   end

   // ------------------------------------------------------------
   // modulated outputs
   // ------------------------------------------------------------
   for (genvar n = 1; n <= NC; n++) begin : g_chan
      wire dbl    = (n > 1) && pcfg_reg[pwm_timer_pkg::PCFG_SEL_LSB + n];
      wire ch_en  = pwm_en && pcfg_reg[pwm_timer_pkg::PCFG_OE_LSB + n];
      // all channels share the cycle match, so one period for all
      wire set_ev = dbl ? hit[n-1] : cycle_hit;
      pwm_channel u_chan (
         .ref_clk   (ref_clk),
         .sys_rst   (sys_rst),
         .enable    (ch_en),
         .set_ev    (set_ev),
         .clr_ev    (hit[n]),
         .pwm_level (pwm_out[n])
      );
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   wire [31:0] rd_word =
      addr == pwm_timer_pkg::CTRL_OFFSET      ? 32'(ctrl_reg) :
      addr == pwm_timer_pkg::COUNT_OFFSET     ? 32'(count_reg) :
      addr == pwm_timer_pkg::PRESCALE_OFFSET  ? 32'(pre_limit_reg) :
      addr == pwm_timer_pkg::PRECOUNT_OFFSET  ? 32'(pre_count_reg) :
      addr == pwm_timer_pkg::MATCH_CFG_OFFSET ? 32'(mcfg_reg) :
      is_match(addr)                          ? 32'(shadow_mem[rd_idx]) :
      addr == pwm_timer_pkg::PWM_CFG_OFFSET   ? 32'(pcfg_reg) :
      addr == pwm_timer_pkg::RELEASE_OFFSET   ? 32'(release_reg) :
      addr == pwm_timer_pkg::STATUS_OFFSET    ? 32'(status_reg) :
      addr == pwm_timer_pkg::MASK_OFFSET      ? 32'(mask_reg) : 32'h00000000;

   // unmapped reads return zero; data lives for one cycle only
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata <= 32'h00000000;
      end else begin
         rdata <= rd_stb ? rd_word : 32'h00000000;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_pre_wrap;
      @(posedge ref_clk) disable iff (sys_rst)
      (active && src_ev && pre_count_reg == pre_limit_reg) |=> (pre_count_reg == '0);
   endproperty
   a_pre_wrap: assert property (p_pre_wrap)
      else $error("prescaler did not wrap at its limit");

   property p_cycle_reset;
      @(posedge ref_clk) disable iff (sys_rst)
      (tick && pwm_en && !hold && count_reg == active_mem[0]) |=> (count_reg == '0);
   endproperty
   a_cycle_reset: assert property (p_cycle_reset)
      else $error("counter not reset at cycle match");

   property p_count_step;
      @(posedge ref_clk) disable iff (sys_rst)
      (tick && !hold && !any_rst) |=> (count_reg == $past(count_reg) + CNT_WIDTH'(1));
   endproperty
   a_count_step: assert property (p_count_step)
      else $error("counter did not advance on tick");

   property p_stop;
      @(posedge ref_clk) disable iff (sys_rst)
      (any_stop && !wr_ctrl) |=> !run_en ##1 (count_reg == $past(count_reg));
   endproperty
   a_stop: assert property (p_stop)
      else $error("counter kept running after stop match");

   property p_int_flag;
      @(posedge ref_clk) disable iff (sys_rst)
      (hit[1] && int_cfg[1]) |=> status_reg[1];
   endproperty
   a_int_flag: assert property (p_int_flag)
      else $error("match did not raise its status bit");

   property p_single_rise;
      @(posedge ref_clk) disable iff (sys_rst)
      (pwm_en && pcfg_reg[pwm_timer_pkg::PCFG_OE_LSB + 1] && cycle_hit && !hit[1])
         |=> pwm_out[1];
   endproperty
   a_single_rise: assert property (p_single_rise)
      else $error("single edge output did not rise at cycle start");

   property p_const_low;
      @(posedge ref_clk) disable iff (sys_rst)
      hit[1] |=> !pwm_out[1];
   endproperty
   a_const_low: assert property (p_const_low)
      else $error("output raised although its match hit");

   property p_double_rise;
      @(posedge ref_clk) disable iff (sys_rst)
      (g_chan[2].ch_en && g_chan[2].dbl && hit[1] && !hit[2]) |=> pwm_out[2];
   endproperty
   a_double_rise: assert property (p_double_rise)
      else $error("double edge output missed its rising match");

   property p_hold_value;
      @(posedge ref_clk) disable iff (sys_rst)
      (pwm_en && !apply && $past(pwm_en)) |=> (active_mem[2] == $past(active_mem[2]));
   endproperty
   a_hold_value: assert property (p_hold_value)
      else $error("match value changed outside cycle start");

   property p_quiet;
      @(posedge ref_clk) disable iff (sys_rst)
      !pwm_en [*2] |-> (pwm_out == 6'h00);
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("outputs active in timer mode");

   property p_double_fall;
      @(posedge ref_clk) disable iff (sys_rst)
      (g_chan[2].ch_en && g_chan[2].dbl && hit[2]) |=> !pwm_out[2];
   endproperty
   a_double_fall: assert property (p_double_fall)
      else $error("double edge output missed its falling match");

   property p_irq_level;
      @(posedge ref_clk) disable iff (sys_rst)
      !wr_mask |=> (irq == |(status_reg & mask_reg));
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("interrupt level does not follow unmasked status");
endmodule : pwm_timer

// *** testbench/pwm_load.sv ***
// load model on the six modulated outputs: counts the cycles each output is high
// assumes registered output levels on ref_clk and a clear pulse from the bench
`timescale 1ns/1ps
module pwm_load (
   input  wire logic        ref_clk,
   input  wire logic        clear,
   input  wire logic [6:1]  pwm_out,
   output logic      [15:0] high_cnt [1:6]
);
   always_ff @(posedge ref_clk) begin
      for (int i = 1; i <= 6; i++) begin
         if (clear) begin
            high_cnt[i] <= 16'h0000;
         end else if (pwm_out[i]) begin
            high_cnt[i] <= high_cnt[i] + 16'h0001;
         end
      end
   end
endmodule : pwm_load

// *** testbench/match_based_pwm_timer_tb_top.sv ***
// self-checking bench of the pwm timer: register port tasks, load model, random values
// assumes the register map and timing of the pwm timer package
`timescale 1ns/1ps
module match_based_pwm_timer_tb_top;
   logic        ref_clk;
   logic        sys_rst;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [1:0]  cap_in;
   logic [31:0] rdata;
   logic        irq;
   logic [6:1]  pwm_out;
   logic        clear;
   logic [15:0] high_cnt [1:6];
   logic [31:0] seed;
   logic [31:0] m [0:6];
   int          miscompares;
   int          check_count;

   pwm_timer #(.CNT_WIDTH(32), .PRE_WIDTH(32)) u_pwm_timer (
      .ref_clk(ref_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .cap_in(cap_in), .rdata(rdata),
      .irq(irq), .pwm_out(pwm_out));
   pwm_load u_pwm_load (.ref_clk(ref_clk), .clear(clear), .pwm_out(pwm_out),
      .high_cnt(high_cnt));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction : rnd

   // high cycles per period; events act the cycle after the matching count
   function automatic logic [31:0] exp_high(input int ch);
      if (ch == 2) return m[2] - m[1];
      if (ch == 4) return m[0] + 32'h1 - m[3] + m[4];
      if (m[ch] == m[0]) return 32'h0;
      return m[ch] + 32'h1;
   endfunction : exp_high

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      @(posedge ref_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge ref_clk);
      rd_stb <= 1'b0;
      #1 d = rdata;
      @(posedge ref_clk);
   endtask : rd

   // window of four whole periods, so the phase of the window does not matter
   task automatic check_all();
      clear <= 1'b1;
      @(posedge ref_clk);
      clear <= 1'b0;
      repeat (4 * (m[0] + 1)) @(posedge ref_clk);
      #1;
      for (int ch = 1; ch <= 6; ch++) begin
         check($sformatf("high cycles ch%0d", ch), 32'(high_cnt[ch]), 4 * exp_high(ch));
      end
      @(posedge ref_clk);
   endtask : check_all

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      logic [31:0] d;
      logic [31:0] a;
      logic [31:0] p;
      int          n;
      seed = 32'h0000303A;
      sys_rst = 1'b1;
      addr = 8'h00;
      wdata = 32'h00000000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      cap_in = 2'b00;
      clear = 1'b0;
      miscompares = 0;
      check_count = 0;
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      rd(pwm_timer_pkg::CTRL_OFFSET, d);
      check("ctrl reset", d, 32'h00000000);
      rd(pwm_timer_pkg::MATCH0_OFFSET, d);
      check("cycle match reset", d, 32'h00000000);
      rd(8'h40, d);
      check("unmapped read", d, 32'h00000000);
      // prescaled timer: two reads a fixed distance apart
      p = rnd() % 4;
      wr(pwm_timer_pkg::PRESCALE_OFFSET, p);
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000001);
      rd(pwm_timer_pkg::COUNT_OFFSET, a);
      repeat (10 * (p + 1) - 2) @(posedge ref_clk);
      rd(pwm_timer_pkg::COUNT_OFFSET, d);
      check("count step", d - a, 32'h0000000A);
      // stop with interrupt on match 1
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000002);
      wr(pwm_timer_pkg::PRESCALE_OFFSET, 32'h00000000);
      wr(pwm_timer_pkg::MATCH_CFG_OFFSET, 32'h00000028);
      wr(pwm_timer_pkg::MASK_OFFSET, 32'h00000002);
      m[1] = 32'd20 + rnd() % 30;
      wr(pwm_timer_pkg::MATCH0_OFFSET + 8'h04, m[1]);
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000001);
      for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge ref_clk);
      if (n == 200) begin
         miscompares++;
         give_verdict();
      end
      rd(pwm_timer_pkg::COUNT_OFFSET, d);
      check("stopped count", d, m[1] + 32'h1);
      rd(pwm_timer_pkg::CTRL_OFFSET, d);
      check("run cleared", d & 32'h1, 32'h0);
      rd(pwm_timer_pkg::STATUS_OFFSET, d);
      check("status set", d & 32'h2, 32'h2);
      rd(pwm_timer_pkg::STATUS_OFFSET, d);
      check("status cleared", d & 32'h2, 32'h0);
      check("irq cleared", 32'(irq), 32'h0);
      // reset on match 2 bounds the count
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000002);
      wr(pwm_timer_pkg::MATCH_CFG_OFFSET, 32'h00000080);
      wr(pwm_timer_pkg::MATCH0_OFFSET + 8'h08, 32'h00000007);
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000001);
      for (int i = 0; i < 12; i++) begin
         repeat (rnd() % 5) @(posedge ref_clk);
         rd(pwm_timer_pkg::COUNT_OFFSET, d);
         check("count bound", 32'(d <= 32'h7), 32'h1);
      end
      // mixed single and double edge outputs
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000002);
      wr(pwm_timer_pkg::MATCH_CFG_OFFSET, 32'h00000000);
      m[0] = 32'd12 + rnd() % 12;
      m[1] = 32'd1 + rnd() % (m[0] / 2 - 1);
      m[2] = m[0] / 2 + rnd() % (m[0] / 2);
      m[4] = 32'd1 + rnd() % (m[0] / 2 - 1);
      m[3] = m[0] / 2 + rnd() % (m[0] / 2);
      m[5] = m[0];
      m[6] = 32'd1 + rnd() % (m[0] - 1);
      for (int i = 0; i < 7; i++) begin
         wr(pwm_timer_pkg::MATCH0_OFFSET + 8'(4 * i), m[i]);
      end
      wr(pwm_timer_pkg::PWM_CFG_OFFSET, 32'h00007E14);
      check("outputs while timer only", 32'(pwm_out), 32'h0);
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000005);
      repeat (2 * (m[0] + 1)) @(posedge ref_clk);
      check_all();
      // a new value waits for its release
      p = (m[6] == 32'h1) ? 32'h2 : 32'h1;
      wr(pwm_timer_pkg::MATCH0_OFFSET + 8'h18, p);
      repeat (2 * (m[0] + 1)) @(posedge ref_clk);
      check_all();
      rd(pwm_timer_pkg::MATCH0_OFFSET + 8'h18, d);
      check("shadow readback", d, p);
      wr(pwm_timer_pkg::RELEASE_OFFSET, 32'h00000040);
      repeat (2 * (m[0] + 1)) @(posedge ref_clk);
      rd(pwm_timer_pkg::RELEASE_OFFSET, d);
      check("release applied", d & 32'h40, 32'h0);
      m[6] = p;
      check_all();
      // counter mode on rising edges of capture input 0 only
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000002);
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000019);
      n = 5 + int'(rnd() % 8);
      for (int i = 0; i < n; i++) begin
         cap_in <= {~cap_in[1], 1'b1};
         @(posedge ref_clk);
         cap_in[0] <= 1'b0;
         @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      rd(pwm_timer_pkg::COUNT_OFFSET, d);
      check("edge count", d, 32'(n));
      // counter mode on falling edges of capture input 1 only
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000002);
      wr(pwm_timer_pkg::CTRL_OFFSET, 32'h00000069);
      for (int i = 0; i < n; i++) begin
         cap_in[1] <= 1'b1;
         @(posedge ref_clk);
         cap_in[1] <= 1'b0;
         @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      rd(pwm_timer_pkg::COUNT_OFFSET, d);
      check("falling edge count", d, 32'(n));
      give_verdict();
   end
endmodule : match_based_pwm_timer_tb_top
